// ===== hw/code_security_lock_defines.vh
// Constants for the code security lock: register map, fields, encodings
`ifndef CODE_SECURITY_LOCK_DEFINES_VH
`define CODE_SECURITY_LOCK_DEFINES_VH

// Register byte addresses
`define CSL_ADDR_CTRL 12'h000
`define CSL_ADDR_STATUS 12'h004
`define CSL_ADDR_REQ 12'h008
`define CSL_ADDR_GRANT 12'h00c
`define CSL_ADDR_ID 12'h010
`define CSL_ADDR_BITS 12'h3ff

// Control register fields
`define CSL_CTRL_PROG_BIT 0
`define CSL_CTRL_KEY_LSB 8
`define CSL_CTRL_KEY_MSB 15
`define CSL_CTRL_KEY 8'ha5
`define CSL_CTRL_MASK 32'h0000_0007

// Status register fields
`define CSL_ST_BITS_LSB 0
`define CSL_ST_BITS_MSB 2
`define CSL_ST_LEVEL_LSB 4
`define CSL_ST_LEVEL_MSB 6
`define CSL_ST_UNDEF_BIT 8
`define CSL_ST_EAL_BIT 9
`define CSL_ST_EAV_BIT 10
`define CSL_ST_REFUSED_BIT 11

// Request register fields
`define CSL_REQ_TREAD_BIT 0
`define CSL_REQ_PROG_BIT 1
`define CSL_REQ_VERIFY_BIT 2
`define CSL_REQ_EXTEXEC_BIT 3
`define CSL_REQ_MASK 32'h0000_000f

// Protection levels
`define CSL_LEVEL_NONE 3'h1
`define CSL_LEVEL_LOCK 3'h2
`define CSL_LEVEL_NOVERIFY 3'h3
`define CSL_LEVEL_NOEXT 3'h4
`define CSL_LEVEL_UNDEF 3'h0

// Cumulative bit patterns
`define CSL_PAT_NONE 3'h0
`define CSL_PAT_B1 3'h1
`define CSL_PAT_B12 3'h3
`define CSL_PAT_B123 3'h7

// Identity value; arbitrary
`define CSL_ID_VALUE 32'h0c51_0001

// AHB-Lite encodings
`define AHB_TRANS_NONSEQ 2'h2
`define AHB_TRANS_SEQ 2'h3
`define AHB_SIZE_WORD 3'h2

`endif

// ===== hw/security_bit_store.v
// Nonvolatile store for the three security bits, one-time programmable
`timescale 1ns/1ns
`include "code_security_lock_defines.vh"

module security_bit_store
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Programming
  input wire program_en,
  input wire [2:0] program_bits,
  // Stored state
  output reg [2:0] security_bits
);

  // Bits only ever go from unprogrammed to programmed; reset does not clear
  // them, modelling cells that survive resets and power cycles.
  reg [2:0] cells;
  initial cells = `CSL_PAT_NONE;

  always @(posedge hclk)
  begin
    if (program_en)
    begin
      cells <= cells | program_bits;
    end
  end

  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      security_bits <= `CSL_PAT_NONE;
    end
    else
    begin
      security_bits <= cells;
    end
  end

endmodule

// ===== hw/security_level_decode.v
// Decodes the security bit pattern into a protection level and gates
`timescale 1ns/1ns
`include "code_security_lock_defines.vh"

module security_level_decode
(
  // Stored bits
  input wire [2:0] security_bits,
  // Decoded protection
  output reg [2:0] level,
  output reg undefined,
  output reg block_table_read,
  output reg lock_ea,
  output reg block_program,
  output reg block_verify,
  output reg block_ext_exec
);

  always @*
  begin
    level = `CSL_LEVEL_UNDEF;
    undefined = 1'b0;
    block_table_read = 1'b0;
    lock_ea = 1'b0;
    block_program = 1'b0;
    block_verify = 1'b0;
    block_ext_exec = 1'b0;
    case (security_bits)
      `CSL_PAT_NONE: level = `CSL_LEVEL_NONE;
      `CSL_PAT_B1: level = `CSL_LEVEL_LOCK;
      `CSL_PAT_B12: level = `CSL_LEVEL_NOVERIFY;
      `CSL_PAT_B123: level = `CSL_LEVEL_NOEXT;
      default: undefined = 1'b1;
    endcase
    // Undefined patterns fail closed: treat as fully locked
    if (undefined || security_bits[0])
    begin
      block_table_read = 1'b1;
      lock_ea = 1'b1;
      block_program = 1'b1;
    end
    if (undefined || (security_bits[0] && security_bits[1]))
    begin
      block_verify = 1'b1;
    end
    if (undefined || (security_bits == `CSL_PAT_B123))
    begin
      block_ext_exec = 1'b1;
    end
  end

endmodule

// ===== hw/code_security_lock.v
// Code security lock: security bits, protection gating and AHB-Lite registers
//
// Contract
// R1: With no security bit programmed, flash stays programmable and verifiable with no restriction.
// R2: With bit 1 programmed, table reads run from external memory cannot obtain internal code bytes.
// R3: With bit 1 programmed, the external-access select input is sampled at reset and held until the next reset.
// R4: With bit 1 programmed, every further programming operation is refused.
// R5: With bits 1 and 2 programmed, bit-1 restrictions stay and verify readout is disabled.
// R6: With all three bits programmed, lower restrictions stay and external execution is prevented.
// R7: The programmer only sets the cumulative patterns none, 1, 1-2 or 1-2-3.
// R8: Unimplemented register bits read back as zero, their reset value.
// R9: Software writes only zeros to unimplemented register bits.
// R10: Security bits persist over resets and the level is evaluated continuously.
//
// Local design decisions: the AHB-Lite register port and the placing of the registers.
`timescale 1ns/1ns
`include "code_security_lock_defines.vh"

module code_security_lock
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // AHB-Lite slave
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire [2:0] hsize,
  input wire [31:0] hwdata,
  input wire hready,
  output reg hreadyout,
  output reg hresp,
  output reg [31:0] hrdata,
  // External-access select pin
  input wire external_access_select,
  // Access requests from the core and programmer
  input wire table_read_ext_req,
  input wire program_req,
  input wire verify_req,
  input wire ext_exec_req,
  // Gated grants
  output reg table_read_ext_grant,
  output reg program_grant,
  output reg verify_grant,
  output reg ext_exec_grant,
  output reg external_access_level
);

  reg ea_meta;
  reg ea_sync;
  reg ea_latched;
  reg ea_captured;
  reg tr_meta;
  reg tr_sync;
  reg pr_meta;
  reg pr_sync;
  reg vr_meta;
  reg vr_sync;
  reg xr_meta;
  reg xr_sync;
  reg [2:0] ctrl_pending;
  reg prog_pulse;
  reg refused;
  reg [3:0] sw_req;
  reg wr_phase;
  reg rd_phase;
  reg [11:0] addr_q;
  reg [31:0] next_hrdata;
  wire [2:0] security_bits;
  wire [2:0] level;
  wire undefined;
  wire block_table_read;
  wire lock_ea;
  wire block_program;
  wire block_verify;
  wire block_ext_exec;
  wire addr_valid;
  wire wr_key_ok;
  wire tr_any;
  wire pr_any;
  wire vr_any;
  wire xr_any;

  function is_mapped;
    input [11:0] a;
    begin
      is_mapped = (a == `CSL_ADDR_CTRL) || (a == `CSL_ADDR_STATUS) ||
        (a == `CSL_ADDR_REQ) || (a == `CSL_ADDR_GRANT) || (a == `CSL_ADDR_ID);
    end
  endfunction

  security_bit_store u_store
  (
    .hclk(hclk),
    .hresetn(hresetn),
    .program_en(prog_pulse),
    .program_bits(ctrl_pending),
    .security_bits(security_bits)
  );

  // Pure combinational decode keeps protection live on every cycle
  security_level_decode u_decode
  (
    .security_bits(security_bits),
    .level(level),
    .undefined(undefined),
    .block_table_read(block_table_read),
    .lock_ea(lock_ea),
    .block_program(block_program),
    .block_verify(block_verify),
    .block_ext_exec(block_ext_exec)
  ); // see R10

  // Pins pass two flops before use
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ea_meta <= 1'b0;
      ea_sync <= 1'b0;
      tr_meta <= 1'b0;
      tr_sync <= 1'b0;
      pr_meta <= 1'b0;
      pr_sync <= 1'b0;
      vr_meta <= 1'b0;
      vr_sync <= 1'b0;
      xr_meta <= 1'b0;
      xr_sync <= 1'b0;
    end
    else
    begin
      ea_meta <= external_access_select;
      ea_sync <= ea_meta;
      tr_meta <= table_read_ext_req;
      tr_sync <= tr_meta;
      pr_meta <= program_req;
      pr_sync <= pr_meta;
      vr_meta <= verify_req;
      vr_sync <= vr_meta;
      xr_meta <= ext_exec_req;
      xr_sync <= xr_meta;
    end
  end

  // Catch the pin once after reset release; the sync delay costs two cycles
  reg [1:0] capture_wait;
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      capture_wait <= 2'h0;
      ea_captured <= 1'b0;
      ea_latched <= 1'b0;
    end
    else if (!ea_captured)
    begin
      if (capture_wait == 2'h2)
      begin
        ea_latched <= ea_sync; // see R3
        ea_captured <= 1'b1;
      end
      else
      begin
        capture_wait <= capture_wait + 2'h1;
      end
    end
  end

  assign tr_any = tr_sync || sw_req[`CSL_REQ_TREAD_BIT];
  assign pr_any = pr_sync || sw_req[`CSL_REQ_PROG_BIT];
  assign vr_any = vr_sync || sw_req[`CSL_REQ_VERIFY_BIT];
  assign xr_any = xr_sync || sw_req[`CSL_REQ_EXTEXEC_BIT];

  // Grants: with nothing programmed every request passes
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      table_read_ext_grant <= 1'b0;
      program_grant <= 1'b0;
      verify_grant <= 1'b0;
      ext_exec_grant <= 1'b0;
      external_access_level <= 1'b0;
    end
    else
    begin
      table_read_ext_grant <= tr_any && !block_table_read; // see R1 see R2
      program_grant <= pr_any && !block_program; // see R1 see R4
      verify_grant <= vr_any && !block_verify; // see R1 see R5
      ext_exec_grant <= xr_any && !block_ext_exec; // see R6
      external_access_level <= lock_ea ? ea_latched : ea_sync; // see R3
    end
  end

  assign addr_valid = hsel && hready && (htrans == `AHB_TRANS_NONSEQ || htrans == `AHB_TRANS_SEQ);
  assign wr_key_ok = hwdata[`CSL_CTRL_KEY_MSB:`CSL_CTRL_KEY_LSB] == `CSL_CTRL_KEY;

  // Address phase capture; always zero wait state, OKAY
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      wr_phase <= 1'b0;
      rd_phase <= 1'b0;
      addr_q <= 12'h000;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      hrdata <= 32'h0000_0000;
    end
    else
    begin
      wr_phase <= addr_valid && hwrite;
      rd_phase <= addr_valid && !hwrite;
      if (addr_valid)
      begin
        addr_q <= haddr;
      end
      hreadyout <= 1'b1;
      hresp <= 1'b0;
      // Read data registered so it stands through the data phase only
      if (addr_valid && !hwrite)
      begin
        hrdata <= next_hrdata;
      end
      else
      begin
        hrdata <= 32'h0000_0000;
      end
    end
  end

  // Writes; programming a bit is refused once bit 1 is programmed
  always @(posedge hclk or negedge hresetn)
  begin
    if (!hresetn)
    begin
      ctrl_pending <= `CSL_PAT_NONE;
      prog_pulse <= 1'b0;
      refused <= 1'b0;
      sw_req <= 4'h0;
    end
    else
    begin
      prog_pulse <= 1'b0;
      if (wr_phase && addr_q == `CSL_ADDR_CTRL)
      begin
        // Only low three bits are kept; the key in bits 15:8 gates programming, other upper bits ignored
        ctrl_pending <= hwdata[2:0]; // see R9
        if (wr_key_ok && !block_program)
        begin
          prog_pulse <= 1'b1;
        end
        else if (wr_key_ok)
        begin
          refused <= 1'b1; // see R4
        end
      end
      else if (wr_phase && addr_q == `CSL_ADDR_STATUS && hwdata[`CSL_ST_REFUSED_BIT])
      begin
        refused <= 1'b0;
      end
      else if (wr_phase && addr_q == `CSL_ADDR_REQ)
      begin
        sw_req <= hwdata[3:0];
      end
    end
  end

  // Read mux; unmapped and unimplemented bits return zero
  always @*
  begin
    next_hrdata = 32'h0000_0000;
    if (haddr == `CSL_ADDR_CTRL)
    begin
      next_hrdata[2:0] = ctrl_pending;
    end
    else if (haddr == `CSL_ADDR_STATUS)
    begin
      next_hrdata[`CSL_ST_BITS_MSB:`CSL_ST_BITS_LSB] = security_bits;
      next_hrdata[`CSL_ST_LEVEL_MSB:`CSL_ST_LEVEL_LSB] = level;
      next_hrdata[`CSL_ST_UNDEF_BIT] = undefined; // see R7
      next_hrdata[`CSL_ST_EAL_BIT] = lock_ea;
      next_hrdata[`CSL_ST_EAV_BIT] = external_access_level;
      next_hrdata[`CSL_ST_REFUSED_BIT] = refused;
    end
    else if (haddr == `CSL_ADDR_REQ)
    begin
      next_hrdata[3:0] = sw_req;
    end
    else if (haddr == `CSL_ADDR_GRANT)
    begin
      next_hrdata[3:0] = {ext_exec_grant, verify_grant, program_grant, table_read_ext_grant};
    end
    else if (haddr == `CSL_ADDR_ID)
    begin
      next_hrdata = `CSL_ID_VALUE;
    end
    if (!is_mapped(haddr))
    begin
      next_hrdata = 32'h0000_0000; // see R8
    end
  end

endmodule

// ===== dv/code_security_lock_sva.sv
// Port assertions for the code security lock
`timescale 1ns/1ns
`include "code_security_lock_defines.vh"
module csl_checker
(
  // Clock and reset
  input wire hclk,
  input wire hresetn,
  // Bus
  input wire hsel,
  input wire [11:0] haddr,
  input wire [1:0] htrans,
  input wire hwrite,
  input wire hready,
  input wire hreadyout,
  input wire hresp,
  input wire [31:0] hrdata,
  // Requests and grants
  input wire table_read_ext_req,
  input wire verify_req,
  input wire ext_exec_req,
  input wire table_read_ext_grant,
  input wire program_grant,
  input wire verify_grant,
  input wire ext_exec_grant
);
  reg rd_phase;
  default clocking @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  sequence rd_addr;
    hsel && hready && htrans[1] && !hwrite;
  endsequence
  always @(posedge hclk or negedge hresetn)
    if (!hresetn)
      rd_phase <= 1'b0;
    else
      rd_phase <= hsel && hready && htrans[1] && !hwrite;
  a_ready_high: assert property (hreadyout)
    else $error("hreadyout low");
  a_resp_okay: assert property (!hresp)
    else $error("hresp not okay");
  a_rdata_idle: assert property (!rd_phase |-> hrdata == 32'h0)
    else $error("hrdata outside read");
  a_unmapped_zero: assert property (rd_addr ##0 haddr == 12'h020 |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_id_value: assert property (rd_addr ##0 haddr == `CSL_ADDR_ID |=> hrdata == `CSL_ID_VALUE)
    else $error("id mismatch");
  a_tread_level: assert property (table_read_ext_req [*5] ##0 program_grant |-> table_read_ext_grant)
    else $error("table read blocked at open level");
  a_verify_level: assert property (verify_req [*5] ##0 program_grant |-> verify_grant)
    else $error("verify blocked at open level");
  a_ext_level: assert property (ext_exec_req [*5] ##0 verify_grant |-> ext_exec_grant)
    else $error("ext exec blocked below top level");
  a_tread_drop: assert property (!table_read_ext_req [*5] |-> !table_read_ext_grant)
    else $error("grant without request");
endmodule

bind code_security_lock csl_checker csl_checker_inst (.hclk, .hresetn, .hsel, .haddr, .htrans,
  .hwrite, .hready, .hreadyout, .hresp, .hrdata, .table_read_ext_req, .verify_req, .ext_exec_req,
  .table_read_ext_grant, .program_grant, .verify_grant, .ext_exec_grant);

// ===== dv/ext_party.sv
// External programmer and program memory driving the access pins
`timescale 1ns/1ns
module ext_party
(
  // Clock
  input wire hclk,
  // Wanted pin pattern
  input wire [4:0] want,
  // Pins: ea, ext exec, verify, program, table read
  output reg [4:0] pins
);
  initial pins = 5'h0;
  // Levels move just after an edge and are held
  always @(posedge hclk)
    pins <= want;
endmodule

// ===== dv/tb_code_security_lock.sv
// Self-checking bench for the code security lock
`timescale 1ns/1ns
`include "code_security_lock_defines.vh"
module tb_code_security_lock;
  reg hclk = 1'b0;
  reg hresetn = 1'b0;
  reg hsel = 1'b0;
  reg [11:0] haddr = 12'h0;
  reg [1:0] htrans = 2'h0;
  reg hwrite = 1'b0;
  reg [31:0] hwdata = 32'h0;
  reg [4:0] want = 5'h0;
  reg [31:0] rd;
  wire [4:0] pins;
  wire hreadyout;
  wire hresp;
  wire [31:0] hrdata;
  wire [3:0] grant;
  wire eal;
  integer mismatches = 0;
  integer check_count = 0;
  integer bits = 0;
  integer refused = 0;
  integer ea_held = 0;
  integer i;
  code_security_lock code_security_lock_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite,
    .hsize(`AHB_SIZE_WORD), .hwdata, .hready(hreadyout), .hreadyout, .hresp, .hrdata,
    .external_access_select(pins[4]), .table_read_ext_req(pins[0]), .program_req(pins[1]),
    .verify_req(pins[2]), .ext_exec_req(pins[3]), .table_read_ext_grant(grant[0]),
    .program_grant(grant[1]), .verify_grant(grant[2]), .ext_exec_grant(grant[3]),
    .external_access_level(eal));
  ext_party ext_party_inst (.hclk, .want, .pins);
  initial
    forever #50 hclk = ~hclk;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", check_count, mismatches);
      if (mismatches == 0 && check_count > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp)
      begin
        mismatches = mismatches + 1;
        $display("BAD %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  // Single transfer; waits on hready without assuming a count
  task xfer(input w, input [11:0] a, input [31:0] d);
    begin
      hsel <= 1'b1;
      haddr <= a;
      hwrite <= w;
      htrans <= `AHB_TRANS_NONSEQ;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
        @(posedge hclk);
      hsel <= 1'b0;
      htrans <= 2'h0;
      hwdata <= d;
      @(posedge hclk);
      while (hreadyout !== 1'b1)
        @(posedge hclk);
      rd = hrdata;
    end
  endtask
  // Model: level from bits, grants and status word
  task check_all;
    integer lv;
    reg [3:0] g;
    reg ea;
    begin
      repeat (7) @(posedge hclk);
      lv = (bits == 0) ? 1 : (bits == 1) ? 2 : (bits == 3) ? 3 : (bits == 7) ? 4 : 0;
      g = want[3:0] & {lv != 0 && lv != 4, lv == 1 || lv == 2, lv == 1, lv == 1};
      ea = bits[0] ? ea_held[0] : want[4];
      cmp({28'h0, grant}, {28'h0, g});
      cmp({31'h0, eal}, {31'h0, ea});
      xfer(1'b0, `CSL_ADDR_GRANT, 32'h0);
      cmp(rd, {28'h0, g});
      xfer(1'b0, `CSL_ADDR_STATUS, 32'h0);
      cmp(rd, {20'h0, refused[0], ea, bits[0], lv == 0, 1'b0, lv[2:0], 1'b0, bits[2:0]});
    end
  endtask
  task stir(input integer n);
    repeat (n)
    begin
      want <= 5'($urandom);
      check_all;
    end
  endtask
  initial
  begin
    i = $urandom(32'h922e41ae);
    repeat (16) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    stir(6);
    xfer(1'b0, `CSL_ADDR_ID, 32'h0);
    cmp(rd, `CSL_ID_VALUE);
    xfer(1'b0, 12'h020, 32'h0);
    cmp(rd, 32'h0);
    xfer(1'b1, `CSL_ADDR_CTRL, 32'h0000_a503);
    bits = 3;
    stir(6);
    // Pin held high through reset so the latch has a known value
    hresetn <= 1'b0;
    want <= 5'h10;
    repeat (3) @(posedge hclk);
    hresetn <= 1'b1;
    ea_held = 1;
    repeat (6) @(posedge hclk);
    stir(6);
    xfer(1'b1, `CSL_ADDR_CTRL, 32'h0000_a507);
    refused = 1;
    check_all;
    xfer(1'b1, `CSL_ADDR_STATUS, 32'h0000_0800);
    refused = 0;
    check_all;
    conclude;
  end
  initial
  begin
    #400000;
    mismatches = mismatches + 1;
    conclude;
  end
endmodule
